// File: rtl/pbw_top.sv
/*
 * Pushbutton wiper position control: input filtering, press timing,
 * direction handling, position counter and nonvolatile write scheduling.
 * Assumes inputs synchronous to clk and rst asserted at power-up.
 */
`include "pbw_params.svh"

module pbw_top
    import pbw_pkg::*;
#(
    parameter int TICK_CYC = `PBW_TICK_CYC,
    parameter int CONTACT_CYC = `PBW_CONTACT_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic up_contact_n,
    input wire logic down_contact_n,
    input wire logic down_contact_float,
    input wire logic step_in_n,
    input wire logic [5:0] nv_stored_pos,
    input wire logic nv_done,
    output logic [5:0] wiper_pos,
    output logic single_mode,
    output logic dir_up,
    output logic nv_wr_req,
    output logic [5:0] nv_wr_pos
);
    logic [14:0] tick_cnt_ff;
    logic tick_ff;
    logic strap_done_ff;
    logic mode_ff;
    pbw_pos_t pos_ff;
    logic dir_ff;
    logic act_ff;
    logic [9:0] idle_ff;
    logic [2:0] raw_n;
    logic [2:0] clean_n;
    logic [2:0] step_ch;
    logic tgl_req;
    logic tgl_take;
    logic tgl_idle;
    logic idle_flip;
    logic eff_up;
    logic go_up;
    logic go_dn;
    pbw_pos_t nxt_pos;
    logic nxt_dir;

    assign raw_n = {step_in_n, down_contact_n, up_contact_n};

    // ==========================================
    // time base
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_ff <= 15'h0000;
            tick_ff <= 1'b0;
        end
        else if (tick_cnt_ff == 15'(TICK_CYC - 1))
        begin
            tick_cnt_ff <= 15'h0000;
            tick_ff <= 1'b1;
        end
        else
        begin
            tick_cnt_ff <= tick_cnt_ff + 15'h0001;
            tick_ff <= 1'b0;
        end
    end

    // ==========================================
    // mode strap, caught on the first edge after reset release
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strap_done_ff <= 1'b0;
            mode_ff <= 1'b0;
        end
        else if (!strap_done_ff)
        begin
            strap_done_ff <= 1'b1;
            mode_ff <= !down_contact_float && down_contact_n;
        end
    end

    // ==========================================
    // per-channel filter and press timing
    for (genvar ch = 0; ch < `PBW_NUM_CH; ch++)
    begin : g_ch
        localparam int FILT_CYC = (ch == `PBW_CH_STEP) ? `PBW_STEP_MIN_CYC : CONTACT_CYC;
        logic prev_ff;
        logic rep_ff;
        logic [9:0] hold_ff;
        logic hold_hit;
        logic rep_hit;

        // short filter on the digital input allows fast stepping
        pbw_debounce #(
            .STABLE_CYC(FILT_CYC)
        ) u_filt (
            .clk(clk),
            .rst(rst),
            .raw_n(raw_n[ch]),
            .clean_n(clean_n[ch])
        );

        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
                prev_ff <= 1'b1;
            else
                prev_ff <= clean_n[ch];
        end

        // nominal thresholds sit inside the allowed tolerance
        assign hold_hit = !rep_ff && (hold_ff == 10'(`PBW_HOLD_TICKS - 1));
        assign rep_hit = rep_ff && (hold_ff == 10'(`PBW_REPEAT_TICKS - 1));

        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                hold_ff <= 10'h000;
                rep_ff <= 1'b0;
            end
            else if (clean_n[ch])
            begin
                hold_ff <= 10'h000;
                rep_ff <= 1'b0;
            end
            else if (tick_ff)
            begin
                if (hold_hit)
                begin
                    hold_ff <= 10'h000;
                    rep_ff <= 1'b1;
                end
                else if (rep_hit)
                    hold_ff <= 10'h000;
                else
                    hold_ff <= hold_ff + 10'h001;
            end
        end

        // step on each filtered falling edge, then on hold and repeat
        assign step_ch[ch] = strap_done_ff && ((prev_ff && !clean_n[ch])
            || (!clean_n[ch] && tick_ff && (hold_hit || rep_hit)));
    end

    // ==========================================
    // direction and position decision
    assign tgl_req = (mode_ff && step_ch[`PBW_CH_UP]) || step_ch[`PBW_CH_STEP];
    assign tgl_idle = (!mode_ff || clean_n[`PBW_CH_UP]) && clean_n[`PBW_CH_STEP];
    assign idle_flip = tick_ff && act_ff && tgl_idle
        && (idle_ff == 10'(`PBW_IDLE_TICKS - 1));

    always_comb
    begin
        nxt_pos = pos_ff;
        nxt_dir = dir_ff;
        go_up = 1'b0;
        go_dn = 1'b0;
        tgl_take = 1'b0;
        // at an end the only way to go is back
        if (pos_ff == `PBW_POS_MAX)
            eff_up = 1'b0;
        else if (pos_ff == `PBW_POS_MIN)
            eff_up = 1'b1;
        else
            eff_up = dir_ff;
        if (!mode_ff && step_ch[`PBW_CH_UP])
            go_up = 1'b1;
        else if (!mode_ff && step_ch[`PBW_CH_DOWN])
            go_dn = 1'b1;
        else if (tgl_req)
        begin
            tgl_take = 1'b1;
            go_up = eff_up;
            go_dn = !eff_up;
        end
        if (go_up && pos_ff != `PBW_POS_MAX)
            nxt_pos = pos_ff + 6'h01;
        else if (go_dn && pos_ff != `PBW_POS_MIN)
            nxt_pos = pos_ff - 6'h01;
        if (tgl_take)
        begin
            nxt_dir = eff_up;
            if (nxt_pos == `PBW_POS_MAX)
                nxt_dir = 1'b0;
            else if (nxt_pos == `PBW_POS_MIN)
                nxt_dir = 1'b1;
        end
        else if (idle_flip)
            nxt_dir = !dir_ff;
    end

    // ==========================================
    // position register, loaded from storage at power-up
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pos_ff <= `PBW_POS_RST;
        else if (!strap_done_ff)
            pos_ff <= nv_stored_pos;
        else
            pos_ff <= nxt_pos;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dir_ff <= 1'b1;
        else
            dir_ff <= nxt_dir;
    end

    // ==========================================
    // inactivity timer for the toggling inputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            idle_ff <= 10'h000;
            act_ff <= 1'b0;
        end
        else if (tgl_take)
        begin
            idle_ff <= 10'h000;
            act_ff <= 1'b1;
        end
        else if (!tgl_idle)
            idle_ff <= 10'h000;
        else if (idle_flip)
        begin
            idle_ff <= 10'h000;
            act_ff <= 1'b0;
        end
        else if (tick_ff && idle_ff != 10'(`PBW_IDLE_TICKS - 1))
            idle_ff <= idle_ff + 10'h001;
    end

    // ==========================================
    // nonvolatile write scheduling
    pbw_nv_sched u_nv (
        .clk(clk),
        .rst(rst),
        .load(!strap_done_ff),
        .load_pos(nv_stored_pos),
        .pos(pos_ff),
        .tick(tick_ff),
        .nv_done(nv_done),
        .nv_wr_req(nv_wr_req),
        .nv_wr_pos(nv_wr_pos)
    );

    assign wiper_pos = pos_ff;
    assign single_mode = mode_ff;
    assign dir_up = dir_ff;

    // ==========================================
    // checks
    sequence s_dual_up;
        strap_done_ff && !mode_ff && step_ch[`PBW_CH_UP] && pos_ff != `PBW_POS_MAX;
    endsequence

    sequence s_dual_down;
        strap_done_ff && !mode_ff && !step_ch[`PBW_CH_UP] && step_ch[`PBW_CH_DOWN]
            && pos_ff != `PBW_POS_MIN;
    endsequence

    sequence s_top_reached;
        tgl_take && eff_up && pos_ff == 6'h3E ##1 pos_ff == `PBW_POS_MAX;
    endsequence

    dual_up_step_a: assert property (@(posedge clk) disable iff (rst)
        s_dual_up |=> pos_ff == $past(pos_ff) + 6'h01)
        else $error("up press did not advance one position");
    dual_down_step_a: assert property (@(posedge clk) disable iff (rst)
        s_dual_down |=> pos_ff == $past(pos_ff) - 6'h01)
        else $error("down press did not retreat one position");
    single_down_ignored_a: assert property (@(posedge clk) disable iff (rst)
        (strap_done_ff && mode_ff && step_ch[`PBW_CH_DOWN] && !step_ch[`PBW_CH_UP]
            && !step_ch[`PBW_CH_STEP]) |=> $stable(pos_ff))
        else $error("down contact moved wiper in single mode");
    pos_no_wrap_a: assert property (@(posedge clk) disable iff (rst)
        (strap_done_ff && pos_ff == `PBW_POS_MAX) |=> pos_ff != `PBW_POS_MIN)
        else $error("position wrapped past the top");
    dual_end_stop_a: assert property (@(posedge clk) disable iff (rst)
        (!mode_ff && pos_ff == `PBW_POS_MAX && step_ch[`PBW_CH_UP]) |=> pos_ff == `PBW_POS_MAX)
        else $error("wiper left the end in dual mode");
    mode_locked_a: assert property (@(posedge clk) disable iff (rst)
        strap_done_ff |=> strap_done_ff && $stable(mode_ff))
        else $error("mode changed after power-up");
    end_reverse_a: assert property (@(posedge clk) disable iff (rst)
        s_top_reached |-> !dir_ff)
        else $error("direction not reversed at the top");
endmodule

// File: include/pbw_params.svh
/*
 * Timing counts, field positions and reset values for the wiper control.
 * Assumes a 20 MHz block clock; millisecond counts are in 1 ms ticks, except the contact filter time, which is in clock cycles.
 */
`ifndef PBW_PARAMS_SVH
`define PBW_PARAMS_SVH
`define PBW_CLK_HZ 20000000
`define PBW_CYC_PER_US (`PBW_CLK_HZ / 1000000)
`define PBW_TICK_US 1000
`define PBW_TICK_CYC (`PBW_TICK_US * `PBW_CYC_PER_US)
`define PBW_TICK_MS (`PBW_TICK_US / 1000)
`define PBW_CONTACT_MIN_MS 1
`define PBW_CONTACT_CYC (`PBW_CONTACT_MIN_MS * 1000 * `PBW_CYC_PER_US)
`define PBW_STEP_MIN_US 1
`define PBW_STEP_MIN_CYC (`PBW_STEP_MIN_US * `PBW_CYC_PER_US)
`define PBW_HOLD_MS 1000
`define PBW_REPEAT_MS 100
`define PBW_IDLE_MS 1000
`define PBW_NV_DELAY_MS 2000
`define PBW_HOLD_TICKS (`PBW_HOLD_MS / `PBW_TICK_MS)
`define PBW_REPEAT_TICKS (`PBW_REPEAT_MS / `PBW_TICK_MS)
`define PBW_IDLE_TICKS (`PBW_IDLE_MS / `PBW_TICK_MS)
`define PBW_NV_DELAY_TICKS (`PBW_NV_DELAY_MS / `PBW_TICK_MS)
`define PBW_POS_MIN 6'h00
`define PBW_POS_MAX 6'h3F
`define PBW_POS_RST 6'h00
`define PBW_NV_TRIG_BIT 3
`define PBW_NUM_CH 3
`define PBW_CH_UP 0
`define PBW_CH_DOWN 1
`define PBW_CH_STEP 2
`endif

// File: include/pbw_pkg.sv
/*
 * Types shared by the wiper control modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pbw_pkg;
    typedef logic [5:0] pbw_pos_t;
    typedef enum logic [1:0] {
        PBW_NV_IDLE = 2'b00,
        PBW_NV_WAIT = 2'b01,
        PBW_NV_BUSY = 2'b10
    } pbw_nv_state_t;
endpackage

// File: rtl/pbw_debounce.sv
/*
 * Level filter for one active-low step input.
 * Assumes the input is synchronous to clk.
 */
`include "pbw_params.svh"
module pbw_debounce
    import pbw_pkg::*;
#(
    parameter int STABLE_CYC = 20
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic raw_n,
    output logic clean_n
);
    logic [15:0] cnt_ff;
    logic clean_ff;

    // new level taken only after it stood for STABLE_CYC cycles
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff <= 16'h0000;
            clean_ff <= 1'b1;
        end
        else if (raw_n == clean_ff)
        begin
            cnt_ff <= 16'h0000;
        end
        else if (cnt_ff == 16'(STABLE_CYC - 1))
        begin
            cnt_ff <= 16'h0000;
            clean_ff <= raw_n;
        end
        else
        begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    assign clean_n = clean_ff;

    filter_stable_a: assert property (@(posedge clk) disable iff (rst)
        $changed(clean_ff) |-> ($past(raw_n, 1) == clean_ff) && ($past(raw_n, 2) == clean_ff))
        else $error("filtered level changed without a stable input");
endmodule

// File: rtl/pbw_nv_sched.sv
/*
 * Schedules delayed writes of the wiper position to nonvolatile storage.
 * Assumes storage pulses nv_done once per accepted write request.
 */
`include "pbw_params.svh"
module pbw_nv_sched
    import pbw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [5:0] load_pos,
    input wire logic [5:0] pos,
    input wire logic tick,
    input wire logic nv_done,
    output logic nv_wr_req,
    output logic [5:0] nv_wr_pos
);
    pbw_nv_state_t state_ff;
    logic [10:0] timer_ff;
    logic first_ff;
    logic pend_ff;
    logic [5:0] prev_ff;
    logic [5:0] stored_ff;
    logic req_ff;
    logic [5:0] data_ff;
    logic change;
    logic qualify;
    logic expire;

    assign change = (state_ff != PBW_NV_IDLE || !load) && (pos != prev_ff);
    assign qualify = change && (first_ff
        || (pos[`PBW_NV_TRIG_BIT] != stored_ff[`PBW_NV_TRIG_BIT]));
    assign expire = tick && (timer_ff == 11'(`PBW_NV_DELAY_TICKS - 1));

    // ==========================================
    // write scheduling
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= PBW_NV_IDLE;
            timer_ff <= 11'h000;
            pend_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                PBW_NV_IDLE:
                begin
                    timer_ff <= 11'h000;
                    if (qualify)
                        state_ff <= PBW_NV_WAIT;
                end
                PBW_NV_WAIT:
                begin
                    if (qualify)
                        timer_ff <= 11'h000;
                    else if (expire)
                        state_ff <= PBW_NV_BUSY;
                    else if (tick)
                        timer_ff <= timer_ff + 11'h001;
                end
                PBW_NV_BUSY:
                begin
                    timer_ff <= 11'h000;
                    if (nv_done)
                    begin
                        state_ff <= (pend_ff || qualify) ? PBW_NV_WAIT : PBW_NV_IDLE;
                        pend_ff <= 1'b0;
                    end
                    else if (qualify)
                        pend_ff <= 1'b1;
                end
                default:
                    state_ff <= PBW_NV_IDLE;
            endcase
        end
    end

    // ==========================================
    // request and reference value
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            first_ff <= 1'b1;
            prev_ff <= `PBW_POS_RST;
            stored_ff <= `PBW_POS_RST;
            req_ff <= 1'b0;
            data_ff <= `PBW_POS_RST;
        end
        else
        begin
            prev_ff <= load ? load_pos : pos;
            req_ff <= 1'b0;
            if (load)
                stored_ff <= load_pos;
            else if (state_ff == PBW_NV_WAIT && !qualify && expire)
            begin
                req_ff <= 1'b1;
                data_ff <= pos;
                stored_ff <= pos;
                first_ff <= 1'b0;
            end
        end
    end

    assign nv_wr_req = req_ff;
    assign nv_wr_pos = data_ff;

    wait_before_write_a: assert property (@(posedge clk) disable iff (rst)
        req_ff |-> $past(timer_ff) == 11'(`PBW_NV_DELAY_TICKS - 1) && $past(tick))
        else $error("write issued before the settle delay");
    one_write_open_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff == PBW_NV_BUSY && !nv_done) |=> !req_ff)
        else $error("second write issued before completion");
endmodule

// File: tb/pbw_far_side.sv
/*
 * Far-side model: buttons, a digital step source and the storage cells.
 * Assumes a free-running clk; lines are driven 1 ns after its rising edge.
 */
`include "pbw_params.svh"
module pbw_far_side
    import pbw_pkg::*;
#(
    parameter int NV_LAT = 30
)
(
    input wire logic clk,
    output logic up_contact_n,
    output logic down_contact_n,
    output logic down_contact_float,
    output logic step_in_n,
    output logic [5:0] nv_stored_pos,
    output logic nv_done,
    input wire logic nv_wr_req,
    input wire logic [5:0] nv_wr_pos
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // idle levels: pulled-up lines sit high
    initial
    begin
        up_contact_n = 1'b1;
        down_contact_n = 1'b1;
        down_contact_float = 1'b1;
        step_in_n = 1'b1;
        nv_stored_pos = 6'h00;
        nv_done = 1'b0;
    end

    // ==========================================
    // strap and storage preset, set before power-up
    task automatic strap(input bit single);
        down_contact_n = 1'b1;
        down_contact_float = !single;
    endtask

    task automatic preset(input logic [5:0] pos);
        nv_stored_pos = pos;
    endtask

    // ==========================================
    // line drivers
    task automatic level(input int ch, input logic v);
        @(posedge clk);
        #1;
        if (ch == `PBW_CH_UP)
            up_contact_n = v;
        else if (ch == `PBW_CH_DOWN)
            down_contact_n = v;
        else
            step_in_n = v;
    endtask

    // low for lo cycles, then high for hi cycles
    task automatic press(input int ch, input int lo, input int hi);
        level(ch, 1'b0);
        repeat (lo - 1) @(posedge clk);
        level(ch, 1'b1);
        repeat (hi - 1) @(posedge clk);
        #1;
    endtask

    // one-cycle chatter shorter than any filter
    task automatic bounce(input int ch, input int n);
        repeat (n)
        begin
            level(ch, 1'b0);
            level(ch, 1'b1);
        end
    endtask

    // ==========================================
    // storage: records a request, reports done after NV_LAT cycles
    initial
    begin
        logic [5:0] held;
        forever
        begin
            @(posedge clk);
            #1;
            if (nv_wr_req === 1'b1)
            begin
                held = nv_wr_pos;
                repeat (NV_LAT) @(posedge clk);
                #1 nv_done = 1'b1;
                @(posedge clk);
                #1 nv_done = 1'b0;
                nv_stored_pos = held;
            end
        end
    end
endmodule

// File: tb/test_pbw_top.sv
/*
 * Self-checking bench for the wiper control, with shortened time base.
 * Assumes pbw_far_side drives all step inputs and answers storage writes.
 */
`include "pbw_params.svh"
module test_pbw_top
    import pbw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int TCYC = 4;
    localparam int UP = `PBW_CH_UP;
    localparam int DN = `PBW_CH_DOWN;
    localparam int ST = `PBW_CH_STEP;

    logic clk;
    logic rst;
    logic up_contact_n;
    logic down_contact_n;
    logic down_contact_float;
    logic step_in_n;
    pbw_pos_t nv_stored_pos;
    logic nv_done;
    pbw_pos_t wiper_pos;
    logic single_mode;
    logic dir_up;
    logic nv_wr_req;
    pbw_pos_t nv_wr_pos;
    int n_mismatch = 0;
    int check_count = 0;

    pbw_top #(.TICK_CYC(TCYC), .CONTACT_CYC(TCYC)) pbw_top_inst (
        .clk(clk), .rst(rst), .up_contact_n(up_contact_n), .down_contact_n(down_contact_n),
        .down_contact_float(down_contact_float), .step_in_n(step_in_n),
        .nv_stored_pos(nv_stored_pos), .nv_done(nv_done), .wiper_pos(wiper_pos),
        .single_mode(single_mode), .dir_up(dir_up), .nv_wr_req(nv_wr_req),
        .nv_wr_pos(nv_wr_pos)
    );

    pbw_far_side pbw_far_side_inst (
        .clk(clk), .up_contact_n(up_contact_n), .down_contact_n(down_contact_n),
        .down_contact_float(down_contact_float), .step_in_n(step_in_n),
        .nv_stored_pos(nv_stored_pos), .nv_done(nv_done), .nv_wr_req(nv_wr_req),
        .nv_wr_pos(nv_wr_pos)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================
    // common tasks
    task automatic wrap_up();
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic pos_is(input logic [7:0] exp);
        chk({2'h0, wiper_pos}, exp, "wiper");
    endtask

    task automatic do_reset(input bit single, input bit keep, input logic [5:0] pos);
        @(posedge clk);
        #1;
        pbw_far_side_inst.strap(single);
        if (!keep)
            pbw_far_side_inst.preset(pos);
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wait_req(input int lim, output bit seen, output int c);
        seen = 1'b0;
        for (c = 0; c < lim && !seen; c++)
        begin
            @(posedge clk);
            #1;
            if (nv_wr_req === 1'b1)
                seen = 1'b1;
        end
    endtask

    task automatic need_req(output int c);
        bit seen;
        wait_req(9000, seen, c);
        if (!seen)
        begin
            n_mismatch++;
            $display("unexpected at %0t: no storage write", $time);
            wrap_up();
        end
    endtask

    // ==========================================
    // scenarios
    task automatic s_dual_ends();
        do_reset(0, 0, 6'h3E);
        chk({7'h00, single_mode}, 8'h00, "mode");
        pos_is(8'h3E);
        pbw_far_side_inst.press(UP, 20, 20);
        pos_is(8'h3F);
        pbw_far_side_inst.press(UP, 20, 20);
        pos_is(8'h3F);
        pbw_far_side_inst.press(DN, 20, 20);
        pos_is(8'h3E);
        pbw_far_side_inst.press(ST, 25, 25);
        pos_is(8'h3F);
    endtask

    task automatic s_merge_bounce();
        pbw_far_side_inst.level(DN, 1'b0);
        repeat (10) @(posedge clk);
        pbw_far_side_inst.level(DN, 1'b1);
        pbw_far_side_inst.level(DN, 1'b0);
        repeat (10) @(posedge clk);
        pbw_far_side_inst.press(DN, 1, 20);
        pos_is(8'h3E);
        pbw_far_side_inst.bounce(DN, 3);
        pbw_far_side_inst.press(DN, 20, 20);
        pos_is(8'h3D);
    endtask

    task automatic s_hold();
        do_reset(0, 0, 6'h10);
        pbw_far_side_inst.press(UP, 1000 * TCYC + 300 * TCYC + 200, 20);
        pos_is(8'h15);
    endtask

    task automatic s_single();
        do_reset(1, 0, 6'h05);
        chk({7'h00, single_mode}, 8'h01, "mode");
        pbw_far_side_inst.press(UP, 20, 20);
        pos_is(8'h06);
        pbw_far_side_inst.press(DN, 20, 20);
        pos_is(8'h06);
        pbw_far_side_inst.press(ST, 25, 25);
        pos_is(8'h07);
        repeat (3800) @(posedge clk);
        #1;
        chk({7'h00, dir_up}, 8'h01, "dir");
        repeat (400) @(posedge clk);
        #1;
        chk({7'h00, dir_up}, 8'h00, "dir");
        pbw_far_side_inst.press(UP, 20, 20);
        pos_is(8'h06);
    endtask

    task automatic s_single_end();
        do_reset(1, 0, 6'h3E);
        pbw_far_side_inst.press(UP, 20, 20);
        pos_is(8'h3F);
        chk({7'h00, dir_up}, 8'h00, "dir");
        pbw_far_side_inst.press(UP, 20, 20);
        pos_is(8'h3E);
    endtask

    task automatic s_nv();
        int c;
        bit seen;
        do_reset(0, 0, 6'h00);
        pbw_far_side_inst.press(UP, 20, 20);
        need_req(c);
        chk({7'h00, (c >= 7940 && c <= 7980)}, 8'h01, "delay");
        chk({2'h0, nv_wr_pos}, 8'h01, "nv pos");
        repeat (40) @(posedge clk);
        pbw_far_side_inst.press(UP, 20, 20);
        wait_req(9000, seen, c);
        chk({7'h00, seen}, 8'h00, "early write");
        repeat (6) pbw_far_side_inst.press(UP, 20, 20);
        need_req(c);
        chk({2'h0, nv_wr_pos}, 8'h08, "nv pos");
        repeat (40) @(posedge clk);
        do_reset(0, 1, 6'h00);
        pos_is(8'h08);
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        s_dual_ends();
        s_merge_bounce();
        s_hold();
        s_single();
        s_single_end();
        s_nv();
        wrap_up();
    end
endmodule
